// ==== rtl/asm_pkg.sv ====
// constants and types for the alarm status and mask unit
package asm_pkg;
	// register offsets (byte addresses on the plain port)
	localparam logic [9:0] ASM_ADDR_SUMMARY = 10'h2C0;
	localparam logic [9:0] ASM_ADDR_STATUS  = 10'h2C1;
	localparam logic [9:0] ASM_ADDR_MASK    = 10'h2C2;
	localparam logic [9:0] ASM_ADDR_LANE    = 10'h2C4;
	localparam logic [9:0] ASM_ADDR_CTRL    = 10'h2C8;
	// alarm bit positions
	localparam int ASM_BIT_FIFO    = 5;
	localparam int ASM_BIT_PLL     = 4;
	localparam int ASM_BIT_LINK    = 3;
	localparam int ASM_BIT_REALIGN = 2;
	localparam int ASM_BIT_CLK     = 0;
	// control register bit positions
	localparam int ASM_CTRL_SOFT_RST  = 0;
	localparam int ASM_CTRL_PIN_SEL   = 1;
	localparam int ASM_CTRL_MODE_64B  = 2;
	// reset values and writable masks
	localparam logic [7:0] ASM_STATUS_RST = 8'h3F;
	localparam logic [7:0] ASM_MASK_RST   = 8'h3F;
	localparam logic [7:0] ASM_LANE_RST   = 8'hFF;
	localparam logic [7:0] ASM_CTRL_RST   = 8'h00;
	localparam logic [7:0] ASM_ALARM_BITS = 8'h3D;
	localparam logic [7:0] ASM_RSVD_ONE   = 8'h02;
	localparam logic [7:0] ASM_CTRL_BITS  = 8'h06;
	// alarm conditions from the lane, pll and clocking logic
	typedef struct packed {
		logic [7:0] lane_fifo_err;
		logic       pll_locked;
		logic       serial_link_enable;
		logic       data_encoding_state;
		logic       link_start;
		logic       realign_event;
		logic       divider_mismatch;
	} asm_cond_t;
	// register port request
	typedef struct packed {
		logic [9:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} asm_req_t;
endpackage

// ==== rtl/asm_sticky_bit.sv ====
// one sticky alarm flag, set by an event, cleared by a written one
`timescale 1ns/1ps
`default_nettype none
module asm_sticky_bit (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic soft_rst,
	input  wire logic set_in,
	input  wire logic clr_in,
	output var  logic flag_reg
);
	// set beats clear; reset and soft reset force one
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			flag_reg <= 1'b1;
		end else if (soft_rst) begin
			flag_reg <= 1'b1;
		end else if (set_in) begin
			flag_reg <= 1'b1;
		end else if (clr_in) begin
			flag_reg <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/asm_alarm_unit.sv ====
// alarm status, mask, summary and pin routing for the serial link
//
// Overview of operation
// - lane fifo over/underflow sets status bit 5; mask bit 5 hides it
// - serializer pll not locked sets status bit 4; mask bit 4 hides it
// - 8b/10b: link enabled but not in data state sets bit 3
// - 64b/66b: link alarm raised at link start and on realignment
// - clock realignment sets status bit 2; mask bit 2 hides it
// - divider mismatch between channel pairs sets status bit 0
// - mask bit 0 hides clock alarm from summary; status still latches
// - status bit clears on write of one; zero leaves it
// - power-on or soft reset sets status and mask bits 5:0 to one; bits 7:6 read zero
// - summary reads one while any unmasked alarm status bit (5:2, 0) is set
// - selectable routing of summary onto calibration status pin
// - clearing fifo alarm also clears every per-lane fifo alarm bit whose lane has no error that cycle
`timescale 1ns/1ps
`default_nettype none
module asm_alarm_unit
	import asm_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire asm_req_t   bus_req,
	input  wire asm_cond_t  cond,
	output var  logic [7:0] rdata_reg,
	output var  logic       irq_reg,
	output var  logic       calibration_status_pin_reg
);
	wire  logic [7:0] alarm_status; // bits driven by flags and constants
	logic [7:0] alarm_mask_reg;
	logic [7:0] per_lane_fifo_alarm_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] set_vec;
	logic [7:0] clr_vec;
	logic [7:0] summary_next;
	logic       soft_rst;
	logic       wr_status;
	logic       link_start_d_reg;
	logic       link_bad;
	logic       calibration_done;

	assign calibration_done = 1'b0;
	assign soft_rst = bus_req.wr && bus_req.addr == ASM_ADDR_CTRL
		&& bus_req.wdata[ASM_CTRL_SOFT_RST];
	assign wr_status = bus_req.wr && bus_req.addr == ASM_ADDR_STATUS;

	// link alarm condition per encoding mode
	always_comb begin
		if (ctrl_reg[ASM_CTRL_MODE_64B]) begin
			link_bad = (cond.link_start && !link_start_d_reg)
				|| cond.realign_event;
		end else begin
			link_bad = cond.serial_link_enable
				&& !cond.data_encoding_state;
		end
	end

	// set and clear vectors for the sticky flags
	always_comb begin
		set_vec = 8'h00;
		set_vec[ASM_BIT_FIFO]    = |cond.lane_fifo_err;
		set_vec[ASM_BIT_PLL]     = !cond.pll_locked;
		set_vec[ASM_BIT_LINK]    = link_bad;
		set_vec[ASM_BIT_REALIGN] = cond.realign_event;
		set_vec[ASM_BIT_CLK]     = cond.divider_mismatch;
		clr_vec = wr_status ? (bus_req.wdata & ASM_ALARM_BITS)
			: 8'h00;
	end

	// one sticky flag per alarm position
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flag
			if (ASM_ALARM_BITS[gi]) begin : g_live
				asm_sticky_bit u_flag (
					.sys_clk  (sys_clk),
					.reset_n  (reset_n),
					.soft_rst (soft_rst),
					.set_in   (set_vec[gi]),
					.clr_in   (clr_vec[gi]),
					.flag_reg (alarm_status[gi])
				);
			end else begin : g_rsvd
				assign alarm_status[gi] = ASM_RSVD_ONE[gi];
			end
		end
	endgenerate

	// link start edge detector for the 64b/66b case
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			link_start_d_reg <= 1'b0;
		end else begin
			link_start_d_reg <= cond.link_start;
		end
	end

	// mask register, reset and soft reset to 3F (bits 5:0 set)
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			alarm_mask_reg <= ASM_MASK_RST;
		end else if (soft_rst) begin
			alarm_mask_reg <= ASM_MASK_RST;
		end else if (bus_req.wr && bus_req.addr == ASM_ADDR_MASK) begin
			alarm_mask_reg <= bus_req.wdata;
		end
	end

	// per-lane fifo flags; fifo status clear wipes all but lanes with an error that cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			per_lane_fifo_alarm_reg <= ASM_LANE_RST;
		end else if (soft_rst) begin
			per_lane_fifo_alarm_reg <= ASM_LANE_RST;
		end else if (clr_vec[ASM_BIT_FIFO]) begin
			per_lane_fifo_alarm_reg <= cond.lane_fifo_err;
		end else if (bus_req.wr && bus_req.addr == ASM_ADDR_LANE) begin
			per_lane_fifo_alarm_reg <= (per_lane_fifo_alarm_reg
				& ~bus_req.wdata) | cond.lane_fifo_err;
		end else begin
			per_lane_fifo_alarm_reg <= per_lane_fifo_alarm_reg
				| cond.lane_fifo_err;
		end
	end

	// control register: pin select and encoding mode
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= ASM_CTRL_RST;
		end else if (bus_req.wr && bus_req.addr == ASM_ADDR_CTRL) begin
			ctrl_reg <= bus_req.wdata & ASM_CTRL_BITS;
		end
	end

	// summary of unmasked alarms
	always_comb begin
		summary_next = 8'h00;
		summary_next[0] = |(alarm_status & ~alarm_mask_reg
			& ASM_ALARM_BITS);
	end

	// interrupt follows the summary; pin follows it only while pin select is set
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_reg                    <= 1'b0;
			calibration_status_pin_reg <= 1'b0;
		end else begin
			irq_reg <= summary_next[0];
			calibration_status_pin_reg <= ctrl_reg[ASM_CTRL_PIN_SEL]
				? summary_next[0] : calibration_done;
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_reg <= 8'h00;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				ASM_ADDR_SUMMARY: rdata_reg <= summary_next;
				ASM_ADDR_STATUS:  rdata_reg <= alarm_status;
				ASM_ADDR_MASK:    rdata_reg <= alarm_mask_reg;
				ASM_ADDR_LANE:    rdata_reg <= per_lane_fifo_alarm_reg;
				ASM_ADDR_CTRL:    rdata_reg <= ctrl_reg;
				default:          rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// checks on the alarm behaviour
	a_fifo_set_sticks: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (|cond.lane_fifo_err) |=> alarm_status[ASM_BIT_FIFO])
		else $error("fifo alarm not latched");
	a_pll_set_sticks: assert property (@(posedge sys_clk) disable iff
		(!reset_n) !cond.pll_locked |=> alarm_status[ASM_BIT_PLL])
		else $error("pll alarm not latched");
	a_link_8b10b_set: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (!ctrl_reg[ASM_CTRL_MODE_64B] && cond.serial_link_enable
		&& !cond.data_encoding_state) |=> alarm_status[ASM_BIT_LINK])
		else $error("link alarm not latched");
	a_link_64b_start: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (ctrl_reg[ASM_CTRL_MODE_64B] && $rose(cond.link_start))
		|=> alarm_status[ASM_BIT_LINK])
		else $error("link start alarm missing");
	a_realign_set: assert property (@(posedge sys_clk) disable iff
		(!reset_n) cond.realign_event |=> alarm_status[ASM_BIT_REALIGN])
		else $error("realign alarm missing");
	a_clk_alarm_set: assert property (@(posedge sys_clk) disable iff
		(!reset_n) cond.divider_mismatch |=> alarm_status[ASM_BIT_CLK])
		else $error("clock alarm missing");
	a_clk_masked_out: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (alarm_status == 8'h03 && alarm_mask_reg[ASM_BIT_CLK])
		|=> !irq_reg) else $error("masked clock alarm raised irq");
	a_clear_holds: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (wr_status && bus_req.wdata[ASM_BIT_PLL] && !soft_rst
		&& cond.pll_locked) |=> !alarm_status[ASM_BIT_PLL])
		else $error("write one did not clear");
	a_soft_reset_ones: assert property (@(posedge sys_clk) disable iff
		(!reset_n) soft_rst |=> (alarm_status == ASM_STATUS_RST
		&& alarm_mask_reg == ASM_MASK_RST))
		else $error("soft reset values wrong");
	a_irq_summary: assert property (@(posedge sys_clk) disable iff
		(!reset_n) irq_reg == $past(|(alarm_status & ~alarm_mask_reg
		& ASM_ALARM_BITS))) else $error("irq does not match summary");
	a_pin_route: assert property (@(posedge sys_clk) disable iff
		(!reset_n) ctrl_reg[ASM_CTRL_PIN_SEL] |=>
		(calibration_status_pin_reg == irq_reg))
		else $error("pin not showing summary");
	a_lane_wipe: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (clr_vec[ASM_BIT_FIFO] && !soft_rst
		&& cond.lane_fifo_err == 8'h00) |=> per_lane_fifo_alarm_reg == 8'h00)
		else $error("lane flags not wiped");
	a_set_wins: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (clr_vec[ASM_BIT_REALIGN] && cond.realign_event)
		|=> alarm_status[ASM_BIT_REALIGN])
		else $error("clear beat set");

	// unmasked alarms reach the interrupt one cycle later
	a_fifo_unmasked_irq: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (alarm_status[ASM_BIT_FIFO] && !alarm_mask_reg[ASM_BIT_FIFO])
		|=> irq_reg) else $error("fifo alarm did not raise irq");
	a_pll_unmasked_irq: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (alarm_status[ASM_BIT_PLL] && !alarm_mask_reg[ASM_BIT_PLL])
		|=> irq_reg) else $error("pll alarm did not raise irq");
	a_link_unmasked_irq: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (alarm_status[ASM_BIT_LINK] && !alarm_mask_reg[ASM_BIT_LINK])
		|=> irq_reg) else $error("link alarm did not raise irq");
	a_realign_unmasked_irq: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (alarm_status[ASM_BIT_REALIGN]
		&& !alarm_mask_reg[ASM_BIT_REALIGN])
		|=> irq_reg) else $error("realign alarm did not raise irq");
	a_clk_unmasked_irq: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (alarm_status[ASM_BIT_CLK] && !alarm_mask_reg[ASM_BIT_CLK])
		|=> irq_reg) else $error("clock alarm did not raise irq");

	// 64b/66b realignment also raises the link alarm
	a_link_64b_realign: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (ctrl_reg[ASM_CTRL_MODE_64B] && cond.realign_event)
		|=> alarm_status[ASM_BIT_LINK])
		else $error("link alarm missing on realign");

	// reserved status bits read their fixed values
	a_rsvd_bits: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (alarm_status[7:6] == 2'b00 && alarm_status[1]))
		else $error("reserved status bits wrong");

	// written zeros leave status bits alone
	a_clear_zero_keeps: assert property (@(posedge sys_clk) disable iff
		(!reset_n) wr_status |=> ((~alarm_status
		& $past(alarm_status & ~bus_req.wdata)) == 8'h00))
		else $error("status bit lost on zero write");

	// soft reset side effects on lanes and control
	a_soft_reset_lane: assert property (@(posedge sys_clk) disable iff
		(!reset_n) soft_rst |=> per_lane_fifo_alarm_reg == ASM_LANE_RST)
		else $error("soft reset lane value wrong");
	a_ctrl_self_clear: assert property (@(posedge sys_clk) disable iff
		(!reset_n) soft_rst |=> !ctrl_reg[ASM_CTRL_SOFT_RST])
		else $error("soft reset bit did not self clear");

	// per-lane flags only drop on a write and always catch errors
	a_lane_sticky: assert property (@(posedge sys_clk) disable iff
		(!reset_n) !bus_req.wr |=> ((~per_lane_fifo_alarm_reg
		& $past(per_lane_fifo_alarm_reg)) == 8'h00))
		else $error("lane flag dropped without write");
	a_lane_set: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (|cond.lane_fifo_err) |=> ((per_lane_fifo_alarm_reg
		& $past(cond.lane_fifo_err)) == $past(cond.lane_fifo_err)))
		else $error("lane error not latched");
	a_lane_write_clear: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (bus_req.wr && bus_req.addr == ASM_ADDR_LANE
		&& cond.lane_fifo_err == 8'h00) |=> ((per_lane_fifo_alarm_reg
		& $past(bus_req.wdata)) == 8'h00))
		else $error("lane write one did not clear");

	// mask register takes written values
	a_mask_write: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (bus_req.wr && bus_req.addr == ASM_ADDR_MASK)
		|=> alarm_mask_reg == $past(bus_req.wdata))
		else $error("mask write lost");

	// read port: data only after a strobe, summary in bit 0
	a_rdata_idle_zero: assert property (@(posedge sys_clk) disable iff
		(!reset_n) !bus_req.rd |=> rdata_reg == 8'h00)
		else $error("read data without strobe");
	a_summary_read: assert property (@(posedge sys_clk) disable iff
		(!reset_n) (bus_req.rd && bus_req.addr == ASM_ADDR_SUMMARY)
		|=> (rdata_reg[7:1] == 7'h00 && rdata_reg[0]
		== $past(|(alarm_status & ~alarm_mask_reg & ASM_ALARM_BITS))))
		else $error("summary read wrong");

	// pin stays low while not routed
	a_pin_default: assert property (@(posedge sys_clk) disable iff
		(!reset_n) !ctrl_reg[ASM_CTRL_PIN_SEL]
		|=> !calibration_status_pin_reg)
		else $error("pin high while not routed");

	c_irq_rise: cover property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(irq_reg));
	c_clear_all: cover property (@(posedge sys_clk) disable iff (!reset_n)
		wr_status && bus_req.wdata == ASM_ALARM_BITS);
	c_set_and_clear: cover property (@(posedge sys_clk) disable iff
		(!reset_n) clr_vec[ASM_BIT_FIFO] && |cond.lane_fifo_err);
	c_soft_reset: cover property (@(posedge sys_clk) disable iff
		(!reset_n) soft_rst);
	c_link_64b: cover property (@(posedge sys_clk) disable iff
		(!reset_n) ctrl_reg[ASM_CTRL_MODE_64B] && link_bad);
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the alarm status and mask unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin \
	err_total++; $display("wrong value at %0t: %s", $time, m); end end
module tb_top
	import asm_pkg::*;
;
	logic       sys_clk;
	logic       reset_n;
	asm_req_t   bus_req;
	asm_cond_t  cond;
	logic [7:0] rdata_reg;
	logic       irq_reg;
	logic       pin_reg;
	int         err_total;
	int         total_checks;

	asm_alarm_unit DUT (
		.sys_clk                    (sys_clk),
		.reset_n                    (reset_n),
		.bus_req                    (bus_req),
		.cond                       (cond),
		.rdata_reg                  (rdata_reg),
		.irq_reg                    (irq_reg),
		.calibration_status_pin_reg (pin_reg)
	);

	// clock generation
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
		#1;
	endtask

	// one-cycle read strobe, data sampled the cycle after
	task automatic chk_rd(input logic [9:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1;
		`CHK(rdata_reg, e, "register read")
	endtask

	// raise or drop one alarm condition
	task automatic drive(input int i, input logic on);
		@(posedge sys_clk);
		case (i)
			0: cond.lane_fifo_err <= on ? 8'h04 : 8'h00;
			1: cond.pll_locked <= !on;
			2: cond.serial_link_enable <= on;
			3: cond.realign_event <= on;
			default: cond.divider_mismatch <= on;
		endcase
	endtask

	task automatic t_reset();
		`CHK(irq_reg, 1'b0, "irq after reset")
		chk_rd(ASM_ADDR_STATUS, 8'h3F);
		chk_rd(ASM_ADDR_MASK, 8'h3F);
		chk_rd(ASM_ADDR_LANE, 8'hFF);
		chk_rd(ASM_ADDR_SUMMARY, 8'h00);
	endtask

	// each alarm latches alone and clears on a written one
	task automatic t_set_clear();
		int pos[5];
		pos = '{ASM_BIT_FIFO, ASM_BIT_PLL, ASM_BIT_LINK, ASM_BIT_REALIGN,
			ASM_BIT_CLK};
		wr(ASM_ADDR_STATUS, 8'h3F);
		chk_rd(ASM_ADDR_STATUS, ASM_RSVD_ONE);
		chk_rd(ASM_ADDR_LANE, 8'h00);
		wr(ASM_ADDR_STATUS, 8'h02);
		chk_rd(ASM_ADDR_STATUS, ASM_RSVD_ONE);
		for (int i = 0; i < 5; i++) begin
			drive(i, 1'b1);
			drive(i, 1'b0);
			tick(2);
			chk_rd(ASM_ADDR_STATUS, ASM_RSVD_ONE | (8'h01 << pos[i]));
			if (i == 0) begin
				chk_rd(ASM_ADDR_LANE, 8'h04);
			end
			wr(ASM_ADDR_STATUS, ASM_RSVD_ONE | (8'h01 << pos[i]));
			chk_rd(ASM_ADDR_STATUS, ASM_RSVD_ONE);
		end
	endtask

	// masking, summary, pin routing and set-over-clear
	task automatic t_mask();
		wr(ASM_ADDR_MASK, 8'h2F);
		drive(1, 1'b1);
		drive(1, 1'b0);
		tick(2);
		`CHK(irq_reg, 1'b1, "irq on unmasked alarm")
		chk_rd(ASM_ADDR_SUMMARY, 8'h01);
		`CHK(pin_reg, 1'b0, "pin not selected")
		wr(ASM_ADDR_CTRL, 8'h02);
		tick(2);
		`CHK(pin_reg, 1'b1, "pin carries summary")
		wr(ASM_ADDR_MASK, 8'h3F);
		tick(2);
		`CHK(irq_reg, 1'b0, "masked alarm hidden")
		drive(4, 1'b1);
		drive(4, 1'b0);
		tick(2);
		`CHK(irq_reg, 1'b0, "clock alarm masked")
		chk_rd(ASM_ADDR_STATUS, 8'h13);
		drive(1, 1'b1);
		wr(ASM_ADDR_STATUS, 8'h12);
		drive(1, 1'b0);
		chk_rd(ASM_ADDR_STATUS, 8'h13);
		wr(ASM_ADDR_STATUS, 8'h3F);
		chk_rd(ASM_ADDR_STATUS, ASM_RSVD_ONE);
	endtask

	// 64b/66b link alarm on link start and realignment
	task automatic t_mode64();
		wr(ASM_ADDR_CTRL, 8'h04);
		@(posedge sys_clk);
		cond.link_start <= 1'b1;
		tick(2);
		chk_rd(ASM_ADDR_STATUS, 8'h0A);
		wr(ASM_ADDR_STATUS, 8'h0A);
		tick(2);
		chk_rd(ASM_ADDR_STATUS, ASM_RSVD_ONE);
		drive(3, 1'b1);
		drive(3, 1'b0);
		tick(2);
		chk_rd(ASM_ADDR_STATUS, 8'h0E);
	endtask

	// soft reset restores defaults; unmapped reads give zero
	task automatic t_soft();
		wr(ASM_ADDR_MASK, 8'h02);
		wr(ASM_ADDR_SUMMARY, 8'hFF);
		chk_rd(ASM_ADDR_SUMMARY, 8'h01);
		wr(ASM_ADDR_CTRL, 8'h01);
		chk_rd(ASM_ADDR_STATUS, 8'h3F);
		chk_rd(ASM_ADDR_MASK, 8'h3F);
		chk_rd(ASM_ADDR_LANE, 8'hFF);
		chk_rd(ASM_ADDR_CTRL, 8'h00);
		chk_rd(10'h2C3, 8'h00);
	endtask

	task automatic tally_and_finish();
		if (err_total == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// watchdog against a hung sequence
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_total++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		err_total = 0;
		total_checks = 0;
		reset_n = 1'b0;
		bus_req = '{addr: 10'h000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
		cond = '{lane_fifo_err: 8'h00, pll_locked: 1'b1,
			serial_link_enable: 1'b0, data_encoding_state: 1'b0,
			link_start: 1'b0, realign_event: 1'b0, divider_mismatch: 1'b0};
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		tick(1);
		t_reset();
		t_set_clear();
		t_mask();
		t_mode64();
		t_soft();
		tally_and_finish();
	end
endmodule
`default_nettype wire
